/* File: logic/bstap_port.sv */
// bstap_port: boundary-scan test access port with idcode, bypass and scan ring
//
// Functional notes
// - port behaves as a standard serial boundary-scan access port.
// - power-up puts controller in test-logic-reset; idle until tck edges.
// - all test inputs are sampled on the rising tck edge only.
// - every tdo change is launched from the falling tck edge.
// - tms sampled each rising edge advances the controller state machine.
// - undriven tms acts as logic one.
// - undriven tdi acts as logic one, shifting ones in.
// - one serial register sits between tdi and tdo, chosen by state and instruction.
// - tdo is driven only in shift states, otherwise released.
// - no test reset pin; reset by tms sequence or power-up only.
// - five consecutive tms-high samples reach test-logic-reset from any state.
// - three-bit instruction register preloads idcode at power-up and in reset state.
// - bypass instruction gives a one-stage register between tdi and tdo.
`timescale 1ns/1ps
module bstap_port
    import bstap_pkg::*;
(
    input wire logic clk, // ram-side system clock
    input wire logic sys_rst, // power-up reset, sync to clk, active high
    input wire logic tck, // test clock from the scan controller
    input wire logic tms, // mode select pin level
    input wire logic tms_driven, // pad sees tms actively driven
    input wire logic tdi, // serial data in pin level
    input wire logic tdi_driven, // pad sees tdi actively driven
    output logic tdo, // serial data out
    output logic tdo_oe, // tdo output enable, high while driving
    input wire logic [BSR_W-1:0] ring_in, // ram pin levels for the scan ring
    output logic [BSR_W-1:0] ring_drv, // scan ring update register contents
    output logic ring_drv_en, // external test drives ring_drv onto pins
    output logic ring_hiz, // sample-z: ram output drivers held off
    output logic extest_sys, // external test active, clk domain
    output logic tap_reset_sys // controller in test-logic-reset, clk domain
);
    typedef struct packed {
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic [ID_W-1:0] id_sh;
        logic [BSR_W-1:0] bsr_sh;
        logic [BSR_W-1:0] upd;
        logic byp;
        logic drv_en;
        logic hiz;
        logic in_tlr;
        logic [2:0] ones;
    } bstap_tck_t;

    typedef struct packed {
        logic tdo;
        logic oe;
    } bstap_neg_t;

    bstap_tck_t t_q;
    bstap_tck_t t_d;
    bstap_neg_t o_q;
    bstap_neg_t o_d;

    logic rst_t;
    logic [BSR_W-1:0] ring_s;
    bstap_state_t state;
    logic tms_eff;
    logic tdi_eff;
    logic sel_bsr;
    logic sel_id;
    logic shifting;

    // no test reset pin: power-up reset is carried into the tck domain
    bstap_sync #(.W(1)) u_rst_sync (
        .clk(tck),
        .rst(1'b0),
        .d(sys_rst),
        .q(rst_t)
    );

    // ram pins change on the ram clock; per-bit samples may be ragged mid-transition
    bstap_sync #(.W(BSR_W)) u_ring_sync (
        .clk(tck),
        .rst(rst_t),
        .d(ring_in),
        .q(ring_s)
    );

    // status levels back into the system clock domain
    bstap_sync #(.W(2)) u_sys_sync (
        .clk(clk),
        .rst(sys_rst),
        .d({t_q.drv_en, t_q.in_tlr}),
        .q({extest_sys, tap_reset_sys})
    );

    // pad pull-ups: a floating pin reads as one
    assign tms_eff = tms_driven ? tms : 1'b1;
    assign tdi_eff = tdi_driven ? tdi : 1'b1;

    bstap_ctrl u_ctrl (
        .tck(tck),
        .rst(rst_t),
        .tms(tms_eff),
        .state(state)
    );

    // unknown codes fall back to bypass, keeping the chain length defined
    assign sel_bsr = (t_q.ir == INS_EXTEST) || (t_q.ir == INS_SAMPLE)
        || (t_q.ir == INS_SAMPLE_Z);
    assign sel_id = (t_q.ir == INS_IDCODE);
    assign shifting = (state == ST_SHF_DR) || (state == ST_SHF_IR);

    always_comb begin
        t_d = t_q;
        t_d.in_tlr = (state == ST_TLR);
        if (!tms_eff) begin
            t_d.ones = ONES_ZERO;
        end else if (t_q.ones != TLR_TMS_CNT) begin
            t_d.ones = t_q.ones + ONES_STEP;
        end
        case (state)
            ST_TLR: begin
                t_d.ir = INS_IDCODE;
            end
            ST_CAP_IR: begin
                t_d.ir_sh = IR_CAPTURE;
            end
            ST_SHF_IR: begin
                t_d.ir_sh = {tdi_eff, t_q.ir_sh[IR_W-1:1]};
            end
            ST_UPD_IR: begin
                t_d.ir = t_q.ir_sh;
            end
            ST_CAP_DR: begin
                if (sel_id) begin
                    t_d.id_sh = IDCODE_VAL;
                end else if (sel_bsr) begin
                    t_d.bsr_sh = ring_s;
                end else begin
                    t_d.byp = 1'b0;
                end
            end
            ST_SHF_DR: begin
                if (sel_id) begin
                    t_d.id_sh = {tdi_eff, t_q.id_sh[ID_W-1:1]};
                end else if (sel_bsr) begin
                    t_d.bsr_sh = {tdi_eff, t_q.bsr_sh[BSR_W-1:1]};
                end else begin
                    t_d.byp = tdi_eff;
                end
            end
            ST_UPD_DR: begin
                if (sel_bsr) begin
                    t_d.upd = t_q.bsr_sh;
                end
            end
            default: begin
            end
        endcase
        // the instruction only takes effect once it is in the held register
        t_d.drv_en = (t_q.ir == INS_EXTEST) && (state != ST_TLR);
        t_d.hiz = (t_q.ir == INS_SAMPLE_Z) && (state != ST_TLR);
        if (rst_t) begin
            t_d = '0;
            t_d.ir = INS_IDCODE;
            t_d.in_tlr = 1'b1;
        end
    end

    always_ff @(posedge tck) begin
        t_q <= t_d;
    end

    // output stage: half a cycle after the sampling edge
    always_comb begin
        o_d.oe = shifting;
        if (state == ST_SHF_IR) begin
            o_d.tdo = t_q.ir_sh[0];
        end else if (sel_id) begin
            o_d.tdo = t_q.id_sh[0];
        end else if (sel_bsr) begin
            o_d.tdo = t_q.bsr_sh[0];
        end else begin
            o_d.tdo = t_q.byp;
        end
        if (rst_t) begin
            o_d = '0;
        end
    end

    always_ff @(negedge tck) begin
        o_q <= o_d;
    end

    assign tdo = o_q.tdo;
    assign tdo_oe = o_q.oe;
    assign ring_drv = t_q.upd;
    assign ring_drv_en = t_q.drv_en;
    assign ring_hiz = t_q.hiz;

    default clocking cb @(posedge tck); endclocking
    // rst_t is unknown until tck has run twice, so the pin reset also holds the checks off
    default disable iff (rst_t || sys_rst);

    property p_five_ones;
        (t_q.ones == TLR_TMS_CNT) |-> (state == ST_TLR);
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five tms highs without reset");

    property p_tms_float;
        (!tms_driven) [*5] |=> (state == ST_TLR);
    endproperty
    a_tms_float: assert property (p_tms_float) else $error("floating tms did not reset");

    property p_ir_preload;
        (state == ST_TLR) |=> (t_q.ir == INS_IDCODE);
    endproperty
    a_ir_preload: assert property (p_ir_preload) else $error("ir not idcode after reset");

    property p_power_up;
        $fell(rst_t) |-> (state == ST_TLR) && (t_q.ir == INS_IDCODE) && !tdo_oe;
    endproperty
    a_power_up: assert property (p_power_up) else $error("not idle after power-up");

    property p_oe_shift;
        tdo_oe == ((state == ST_SHF_DR) || (state == ST_SHF_IR));
    endproperty
    a_oe_shift: assert property (p_oe_shift) else $error("tdo enable outside shift state");

    property p_bypass_one;
        (state == ST_SHF_DR && t_q.ir == INS_BYPASS) ##1 (state == ST_SHF_DR)
            |-> (tdo == $past(tdi_eff));
    endproperty
    a_bypass_one: assert property (p_bypass_one) else $error("bypass delay not one stage");

    property p_tdi_float;
        (state == ST_SHF_DR && t_q.ir == INS_BYPASS && !tdi_driven) |=> t_q.byp;
    endproperty
    a_tdi_float: assert property (p_tdi_float) else $error("floating tdi not shifted in");

    property p_id_first;
        (state == ST_CAP_DR && t_q.ir == INS_IDCODE) ##1 (state == ST_SHF_DR)
            |-> (tdo == IDCODE_VAL[0]) && tdo_oe;
    endproperty
    a_id_first: assert property (p_id_first) else $error("idcode bit 0 not first on tdo");

    property p_cap_ir;
        (state == ST_CAP_IR) |=> (t_q.ir_sh == IR_CAPTURE);
    endproperty
    a_cap_ir: assert property (p_cap_ir) else $error("capture-ir pattern wrong");

    property p_upd_ir;
        (state == ST_UPD_IR) |=> (t_q.ir == $past(t_q.ir_sh));
    endproperty
    a_upd_ir: assert property (p_upd_ir) else $error("update-ir did not load ir");

    // looked at on the falling edge: tdo holds what the previous falling edge registered
    property p_tdo_half;
        @(negedge tck) (state == ST_SHF_DR) |-> (tdo == $past(o_d.tdo));
    endproperty
    a_tdo_half: assert property (p_tdo_half) else $error("tdo not from falling edge");

    property p_byp_capture;
        (state == ST_CAP_DR && !sel_id && !sel_bsr) |=> !t_q.byp;
    endproperty
    a_byp_capture: assert property (p_byp_capture) else $error("bypass not cleared");

    property p_ring_capture;
        (state == ST_CAP_DR && sel_bsr) |=> (t_q.bsr_sh == $past(ring_s));
    endproperty
    a_ring_capture: assert property (p_ring_capture) else $error("ring not captured");

    property p_ring_shift;
        (state == ST_SHF_DR && sel_bsr) |-> (tdo == t_q.bsr_sh[0]) && tdo_oe;
    endproperty
    a_ring_shift: assert property (p_ring_shift) else $error("ring bit 0 not on tdo");

    property p_ring_update;
        (state == ST_UPD_DR && sel_bsr) |=> (ring_drv == $past(t_q.bsr_sh));
    endproperty
    a_ring_update: assert property (p_ring_update) else $error("ring update lost");

    property p_ir_held;
        (state != ST_UPD_IR && state != ST_TLR) |=> $stable(t_q.ir);
    endproperty
    a_ir_held: assert property (p_ir_held) else $error("ir moved outside update-ir");

    property p_ir_first;
        (state == ST_CAP_IR) ##1 (state == ST_SHF_IR) |-> (tdo == IR_CAPTURE[0]) && tdo_oe;
    endproperty
    a_ir_first: assert property (p_ir_first) else $error("capture-ir bit 0 not on tdo");

    property p_extest_drive;
        ring_drv_en |-> ($past(t_q.ir) == INS_EXTEST);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("drive without extest");

    property p_hiz_level;
        ring_hiz |-> ($past(t_q.ir) == INS_SAMPLE_Z);
    endproperty
    a_hiz_level: assert property (p_hiz_level) else $error("hiz without sample-z");

    c_idcode: cover property ((state == ST_CAP_DR && sel_id) ##1 (state == ST_SHF_DR) [*8]);
    c_bypass: cover property ((state == ST_SHF_DR && t_q.ir == INS_BYPASS) [*3]);
    c_extest: cover property ((state == ST_UPD_DR && t_q.ir == INS_EXTEST) ##1 ring_drv_en);
    c_new_ir: cover property ((state == ST_UPD_IR) ##1 (t_q.ir == INS_SAMPLE));
    c_tms_reset: cover property ((t_q.ones == TLR_TMS_CNT) ##1 (state == ST_RTI));
endmodule

/* File: inc/bstap_pkg.sv */
// bstap_pkg: constants and types of the boundary-scan test access port
package bstap_pkg;

    // test controller sequencer states
    typedef enum logic [3:0] {
        ST_TLR,
        ST_RTI,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHF_DR,
        ST_EX1_DR,
        ST_PAU_DR,
        ST_EX2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHF_IR,
        ST_EX1_IR,
        ST_PAU_IR,
        ST_EX2_IR,
        ST_UPD_IR
    } bstap_state_t;

    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 8;

    // instruction codes; all-zeros is the external test
    localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [IR_W-1:0] INS_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;

    // pattern captured into the instruction shifter, low two bits 01
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h1;

    // identification word: value arbitrary, bit 0 must stay one
    localparam logic [ID_W-1:0] IDCODE_VAL = 32'h0A5C_3001;

    // consecutive tms-high samples that always reach test-logic-reset
    localparam logic [2:0] TLR_TMS_CNT = 3'h5;
    localparam logic [2:0] ONES_STEP = 3'h1;
    localparam logic [2:0] ONES_ZERO = 3'h0;

endpackage

/* File: logic/bstap_sync.sv */
// bstap_sync: two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ps
module bstap_sync #(
    parameter int W = 1
) (
    input wire logic clk, // destination clock
    input wire logic rst, // synchronous reset, active high
    input wire logic [W-1:0] d, // level from the other domain
    output logic [W-1:0] q // synchronised level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bstap_sync_t;

    bstap_sync_t s_q;
    bstap_sync_t s_d;

    // first stage feeds only the second stage
    always_comb begin
        s_d = s_q;
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
        if (rst) begin
            s_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign q = s_q.s2;
endmodule

/* File: logic/bstap_ctrl.sv */
// bstap_ctrl: sixteen-state test controller sequencer on the test clock
`timescale 1ns/1ps
module bstap_ctrl
    import bstap_pkg::*;
(
    input wire logic tck, // test clock
    input wire logic rst, // power-up reset in tck domain
    input wire logic tms, // effective mode select
    output bstap_state_t state // current controller state
);
    typedef struct packed {
        bstap_state_t st;
    } bstap_ctrl_t;

    bstap_ctrl_t c_q;
    bstap_ctrl_t c_d;

    always_comb begin
        c_d = c_q;
        case (c_q.st)
            ST_TLR: c_d.st = tms ? ST_TLR : ST_RTI;
            ST_RTI: c_d.st = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: c_d.st = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: c_d.st = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_SHF_DR: c_d.st = tms ? ST_EX1_DR : ST_SHF_DR;
            ST_EX1_DR: c_d.st = tms ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: c_d.st = tms ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: c_d.st = tms ? ST_UPD_DR : ST_SHF_DR;
            ST_UPD_DR: c_d.st = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: c_d.st = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: c_d.st = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_SHF_IR: c_d.st = tms ? ST_EX1_IR : ST_SHF_IR;
            ST_EX1_IR: c_d.st = tms ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: c_d.st = tms ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: c_d.st = tms ? ST_UPD_IR : ST_SHF_IR;
            ST_UPD_IR: c_d.st = tms ? ST_SEL_DR : ST_RTI;
            default: c_d.st = ST_TLR;
        endcase
        if (rst) begin
            c_d.st = ST_TLR;
        end
    end

    // tms is only ever looked at on the rising edge
    always_ff @(posedge tck) begin
        c_q <= c_d;
    end

    assign state = c_q.st;

    default clocking cb @(posedge tck); endclocking
    default disable iff (rst);

    property p_rti_to_sel;
        (c_q.st == ST_RTI && tms) |=> (c_q.st == ST_SEL_DR);
    endproperty
    a_rti_to_sel: assert property (p_rti_to_sel) else $error("rti with tms high stayed");

    property p_shift_hold;
        (c_q.st == ST_SHF_DR && !tms) [*2] |=> (c_q.st == ST_SHF_DR);
    endproperty
    a_shift_hold: assert property (p_shift_hold) else $error("shift-dr left with tms low");
endmodule

/* File: testbench/bstap_ctl_model.sv */
// bstap_ctl_model: scan controller model that clocks the test port bit by bit
`timescale 1ns/1ps
module bstap_ctl_model (
    output logic tck, // test clock, still between frames
    output logic tms, // mode select line
    output logic tms_driven, // low models a floating pin
    output logic tdi, // serial data line
    output logic tdi_driven, // low models a floating pin
    input wire logic tdo, // serial data from the port
    input wire logic tdo_oe // port drives tdo
);
    logic flt = 1'b0;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        tms_driven = 1'b1;
        tdi_driven = 1'b1;
    end

    // one tck period: pins change while tck is low, tdo is read just before the rise
    task automatic bt(input logic m, input logic d, input logic dm, input logic dd,
                      output logic o, output logic oe);
        flt = ~flt;
        tms_driven <= dm;
        tdi_driven <= dd;
        // a floating line toggles so a stale level can never pass for a one
        tms <= dm ? m : flt;
        tdi <= dd ? d : ~flt;
        #7.5;
        // a released tdo reads inverted, so a stale level never passes as data
        o = tdo_oe ? tdo : ~tdo;
        oe = tdo_oe;
        tck = 1'b1;
        #7.5;
        tck = 1'b0;
    endtask
endmodule

/* File: testbench/tb_boundary_scan_tap_port.sv */
// tb_boundary_scan_tap_port: self-checking bench of the test access port
`timescale 1ns/1ps
module tb_boundary_scan_tap_port;
    import bstap_pkg::*;
    logic clk, sys_rst, tck, tms, tms_driven, tdi, tdi_driven, tdo, tdo_oe;
    logic [BSR_W-1:0] ring_in, ring_drv;
    logic ring_drv_en, ring_hiz, extest_sys, tap_reset_sys;
    logic dm = 1'b1;
    logic dd = 1'b1;
    int miscompares = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'h0000_0032;

    bstap_port i_bstap_port (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
        .tms_driven(tms_driven), .tdi(tdi), .tdi_driven(tdi_driven), .tdo(tdo),
        .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_drv(ring_drv), .ring_drv_en(ring_drv_en),
        .ring_hiz(ring_hiz), .extest_sys(extest_sys), .tap_reset_sys(tap_reset_sys));
    bstap_ctl_model i_bstap_ctl_model (.tck(tck), .tms(tms), .tms_driven(tms_driven),
        .tdi(tdi), .tdi_driven(tdi_driven), .tdo(tdo), .tdo_oe(tdo_oe));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic bt(input logic m, input logic d);
        logic o, oe;
        i_bstap_ctl_model.bt(m, d, dm, dd, o, oe);
    endtask

    // full scan from idle: capture, shift n bits lsb first, update, back to idle
    task automatic xf(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
        logic o, oe;
        dout = '0;
        bt(1'b1, 1'b0);
        if (ir) begin
            bt(1'b1, 1'b0);
        end
        bt(1'b0, 1'b0);
        bt(1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            i_bstap_ctl_model.bt(i == n - 1, din[i], dm, dd, o, oe);
            dout[i] = o;
            chk(oe, 1'b1, "tdo enable in shift");
        end
        i_bstap_ctl_model.bt(1'b1, 1'b0, dm, dd, o, oe);
        chk(oe, 1'b0, "tdo enable after shift");
        bt(1'b0, 1'b0);
        bt(1'b0, 1'b0);
    endtask

    // output may only move on the falling edge, never while tck is high
    always @(tdo, tdo_oe) begin
        if (tck === 1'b1) begin
            chk(tck, 1'b0, "tdo moved while tck high");
        end
    end

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #500_000;
        miscompares++;
        end_of_test();
    end

    initial begin
        logic [31:0] d, r, p;
        logic [2:0] byp [4];
        int steps;
        byp = '{3'h3, 3'h5, 3'h6, INS_BYPASS};
        sys_rst = 1'b1;
        ring_in = '0;
        #3.3;
        fork
            begin
                repeat (6) @(posedge clk);
                sys_rst <= 1'b0;
            end
            repeat (8) bt(1'b1, 1'b1);
        join
        repeat (4) @(posedge clk);
        chk(tap_reset_sys, 1'b1, "reset flag at power-up");
        chk({ring_drv_en, ring_hiz}, 2'h0, "ring idle at power-up");
        bt(1'b0, 1'b0);
        xf(1'b0, ID_W, xs(), d);
        chk(d, IDCODE_VAL, "idcode after power-up");
        repeat (4) @(posedge clk);
        chk(tap_reset_sys, 1'b0, "reset flag after leaving reset");
        // all unused codes must fall back to a one-stage bypass
        foreach (byp[k]) begin
            xf(1'b1, IR_W, 32'(byp[k]), d);
            chk(d[2:0], IR_CAPTURE, "instruction capture");
            r = xs();
            xf(1'b0, 8, r, d);
            chk(d[7:0], {r[6:0], 1'b0}, "bypass delay");
        end
        dd = 1'b0;
        xf(1'b0, 8, xs(), d);
        dd = 1'b1;
        chk(d[7:0], 8'hFE, "floating tdi shifts ones");
        r = xs();
        p = xs();
        @(posedge clk);
        ring_in <= r[7:0];
        xf(1'b1, IR_W, 32'(INS_SAMPLE), d);
        xf(1'b0, BSR_W, p, d);
        chk(d[7:0], r[7:0], "ring capture");
        chk(ring_drv, p[7:0], "ring update");
        xf(1'b1, IR_W, 32'(INS_SAMPLE_Z), d);
        chk(ring_hiz, 1'b1, "sample-z holds drivers off");
        xf(1'b1, IR_W, 32'(INS_EXTEST), d);
        repeat (4) @(posedge clk);
        chk({ring_drv_en, ring_hiz, extest_sys}, 3'h5, "external test active");
        // five ones from a random state, with the pin floating on odd passes
        for (int k = 0; k < 4; k++) begin
            steps = 1 + (xs() & 32'h0000_000F);
            repeat (steps) bt(1'(xs()), 1'(xs()));
            dm = k[0] ? 1'b0 : 1'b1;
            repeat (5) bt(1'b1, 1'b0);
            dm = 1'b1;
            bt(1'b0, 1'b0);
            chk(ring_drv_en, 1'b0, "external test off after reset");
            xf(1'b0, ID_W, xs(), d);
            chk(d, IDCODE_VAL, "idcode after tms reset");
            xf(1'b1, IR_W, 32'(INS_EXTEST), d);
        end
        // second power-up in mid-run, with the external test still loaded
        fork
            begin
                @(posedge clk);
                sys_rst <= 1'b1;
                repeat (6) @(posedge clk);
                sys_rst <= 1'b0;
            end
            repeat (8) bt(1'b1, 1'b1);
        join
        repeat (4) @(posedge clk);
        chk({ring_drv_en, extest_sys, tap_reset_sys}, 3'h1, "mid-run reset state");
        bt(1'b0, 1'b0);
        xf(1'b0, ID_W, xs(), d);
        chk(d, IDCODE_VAL, "idcode after mid-run reset");
        end_of_test();
    end
endmodule
